// ===== design/sat_ctrl.sv
// External controller for the step attenuator, programmed over APB.
// Assumes PCLK is MCLK; the attenuator samples its pins asynchronously.
//
// Local design decisions: the address map and the APB register port.
`default_nettype none

module sat_ctrl
   import sat_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   sat_if.ctrl LINK
);

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic [1:0] ctrl_q;
   logic [4:0] att_q;
   logic [2:0] tgt_q;
   logic [2:0] pins_q;
   logic busy;
   logic ready_q;
   logic [31:0] rdata_q;
   logic err_q;
   logic go_q;
   logic access;
   logic known;

   assign access = PSEL & PENABLE & ~ready_q;
   assign known = (PADDR == REG_CTRL) || (PADDR == REG_WORD) || (PADDR == REG_PINS)
                  || (PADDR == REG_GO) || (PADDR == REG_STATUS);

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ready_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ready_q <= access;
         err_q <= access & ~known;
         rdata_q <= 32'h0000_0000;
         if (access && !PWRITE) begin
            case (PADDR)
               REG_CTRL: rdata_q <= {30'h0, ctrl_q};
               REG_WORD: rdata_q <= {21'h0, tgt_q, 3'h0, att_q};
               REG_PINS: rdata_q <= {29'h0, pins_q};
               REG_STATUS: rdata_q <= {31'h0, busy};
               default: rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Settings are frozen while a transfer runs so the pins stay coherent
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ctrl_q <= CTRL_RESET;
         att_q <= WORD_ATT_RESET;
         tgt_q <= WORD_TGT_RESET;
         pins_q <= PINS_RESET;
         go_q <= 1'b0;
      end else begin
         go_q <= 1'b0;
         if (access && PWRITE && !busy) begin
            case (PADDR)
               REG_CTRL: ctrl_q <= PWDATA[1:0];
               REG_WORD: begin
                  att_q <= PWDATA[ATT_W-1:0];
                  tgt_q <= PWDATA[WORD_TARGET_LSB +: ADDR_W];
               end
               REG_PINS: pins_q <= PWDATA[ADDR_W-1:0];
               REG_GO: go_q <= 1'b1;
               default: go_q <= 1'b0;
            endcase
         end
      end
   end

   assign PREADY = ready_q;
   assign PRDATA = rdata_q;
   assign PSLVERR = err_q;

   // ----------------------------------------------------------------
   // Link sequencer
   // ----------------------------------------------------------------
   sat_state_type state_q;
   logic [15:0] cnt_q;
   logic [3:0] bit_q;
   logic [15:0] frame;
   logic serial;
   logic direct;
   logic cnt_done;

   assign serial = ctrl_q[CTRL_SERIAL_BIT];
   assign direct = ctrl_q[CTRL_DIRECT_BIT];
   assign busy = (state_q != ST_IDLE);
   assign cnt_done = (cnt_q == 16'h0000);
   // Address word goes high, attenuation word low; shifted LSB first
   assign frame = {5'h00, tgt_q, 3'h0, att_q}; // RQ8 RQ9

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
         cnt_q <= 16'h0000;
         bit_q <= 4'h0;
      end else begin
         if (!cnt_done) begin
            cnt_q <= cnt_q - 16'h0001;
         end
         case (state_q)
            ST_IDLE: begin
               bit_q <= 4'h0;
               if (go_q) begin
                  state_q <= serial ? ST_SETUP : ST_PSETUP;
                  cnt_q <= 16'(serial ? LINK_HALF_CYC - 1 : PAR_SETUP_CYC - 1);
               end
            end
            ST_SETUP: if (cnt_done) begin
               state_q <= ST_HIGH;
               cnt_q <= 16'(LINK_HALF_CYC - 1);
            end
            ST_HIGH: if (cnt_done) begin
               bit_q <= bit_q + 4'h1;
               state_q <= (bit_q == 4'hf) ? ST_LE_HI : ST_SETUP;
               cnt_q <= 16'(LINK_HALF_CYC - 1);
            end
            ST_PSETUP: if (cnt_done) begin
               state_q <= direct ? ST_GAP : ST_LE_HI; // RQ4
               cnt_q <= 16'(direct ? GAP_CYC - 1 : LINK_HALF_CYC - 1);
            end
            ST_LE_HI: if (cnt_done) begin
               state_q <= ST_LE_LO;
               cnt_q <= 16'(LINK_HALF_CYC - 1);
            end
            ST_LE_LO: if (cnt_done) begin
               state_q <= ST_GAP;
               cnt_q <= 16'(GAP_CYC - 1);
            end
            // Holds off the next change to respect the switching rate
            ST_GAP: if (cnt_done) state_q <= ST_IDLE; // RQ14
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   logic sclk_q;
   logic sdata_q;
   logic le_q;
   logic [4:0] par_q;
   logic sel_q;
   logic [2:0] apin_q;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sclk_q <= 1'b0;
         sdata_q <= 1'b0;
         le_q <= 1'b0;
         par_q <= 5'h00;
         sel_q <= 1'b0;
         apin_q <= 3'h0;
      end else begin
         sel_q <= serial;
         apin_q <= pins_q;
         sclk_q <= (state_q == ST_HIGH);
         sdata_q <= frame[bit_q];
         // Strobe stays low through the shift, then one pulse
         le_q <= (state_q == ST_LE_HI) || (!serial && direct); // RQ12 RQ3
         par_q <= serial ? 5'h00 : ((state_q == ST_IDLE) ? par_q : att_q); // RQ13
      end
   end

   assign LINK.ser_sel = sel_q;
   assign LINK.par_bits = par_q;
   assign LINK.par_oe = 1'b1;
   assign LINK.ser_clk = sclk_q;
   assign LINK.ser_data = sdata_q;
   assign LINK.load_strobe = le_q;
   assign LINK.addr_pins = apin_q;

endmodule : sat_ctrl

`default_nettype wire

// ===== design/sat_device.sv
// Control logic of the 5-bit step attenuator: parallel and serial-addressable.
// Assumes every pin is asynchronous to MCLK and the serial clock is far slower.
//
// Behaviour
// (RQ1) Select low parallel, high serial-addressable
// (RQ2) Parallel bits weigh 0.25 to 4 dB
// (RQ3) Controller pulses strobe to latch parallel bits
// (RQ4) Strobe held high: parallel bits pass directly
// (RQ5) Sixteen-bit shift register feeds transparent latch
// (RQ6) Latch only when address word matches pins
// (RQ7) Only address bits 2..0 are compared
// (RQ8) Shift LSB first, attenuation word first
// (RQ9) Attenuation word is four times dB
// (RQ10) Shift on every rising clock edge, any strobe
// (RQ11) Strobe high makes the latch transparent
// (RQ12) Controller keeps strobe low while shifting
// (RQ13) Controller grounds parallel bits in serial mode
// (RQ14) State changes no faster than 25 kHz; a switch into direct mode loads at once, with no gap before the next GO
// (RQ15) Serial data sampled on rising clock edge
// (RQ16) Power-up state is maximum attenuation
// (RQ17) Open parallel input reads as low
`default_nettype none

module sat_device
   import sat_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   sat_if.dev LINK,
   output logic [4:0] ATTEN_STATE,
   output logic SERIAL_MODE,
   output logic [15:0] SHIFT_WORD,
   output logic ADDR_MATCH,
   output logic LATCH_OPEN
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int NPIN = 12;

   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_meta_q;
   logic [NPIN-1:0] pin_sync_q;

   assign pin_raw = {LINK.ser_sel, LINK.par_level, LINK.ser_clk, LINK.ser_data,
                     LINK.load_strobe, LINK.addr_pins};

   // Every pin goes through two flops before any logic looks at it
   // Bits of one word are synchronised one by one; the controller holds
   // them steady far longer than two cycles, so skew between them is harmless
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
               pin_meta_q[gi] <= 1'b0;
               pin_sync_q[gi] <= 1'b0;
            end else begin
               pin_meta_q[gi] <= pin_raw[gi];
               pin_sync_q[gi] <= pin_meta_q[gi];
            end
         end
      end
   endgenerate

   logic sel_s;
   logic [4:0] par_s;
   logic sclk_s;
   logic sdata_s;
   logic strobe_s;
   logic [2:0] apin_s;

   assign sel_s = pin_sync_q[11];
   // Released parallel pins arrive here as low
   assign par_s = pin_sync_q[10:6]; // RQ17
   assign sclk_s = pin_sync_q[5];
   assign sdata_s = pin_sync_q[4];
   assign strobe_s = pin_sync_q[3];
   assign apin_s = pin_sync_q[2:0];

   // ----------------------------------------------------------------
   // Serial clock edge detection
   // ----------------------------------------------------------------
   // Reset value matches the idle low clock, so no false edge follows reset
   logic sclk_prev_q;
   logic sclk_rise;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end

   // Data and clock share the same sync delay, so setup at the pin is kept
   assign sclk_rise = sclk_s & ~sclk_prev_q; // RQ15

   // ----------------------------------------------------------------
   // Shift register
   // ----------------------------------------------------------------
   logic [15:0] shift_q;
   logic [15:0] shift_d;

   // New bit enters at the top, so the first bit ends in bit 0 after 16
   // shifts and the address word lands in the upper byte
   assign shift_d = {sdata_s, shift_q[15:1]}; // RQ8

   // The strobe level does not gate shifting
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         shift_q <= 16'h0000;
      end else if (sclk_rise) begin // RQ10
         shift_q <= shift_d; // RQ5
      end
   end

   // ----------------------------------------------------------------
   // Address compare
   // ----------------------------------------------------------------
   logic [7:0] addr_word;
   logic [7:0] att_word;
   logic match;

   assign addr_word = shift_q[ADDR_LSB +: WORD_LEN];
   assign att_word = shift_q[ATT_LSB +: WORD_LEN];

   // Pins are compared live: a pin change while the strobe is high moves
   // the state at once, so the pins must stay static during the strobe
   // Upper five address bits are don't-care
   assign match = (addr_word[ADDR_W-1:0] == apin_s); // RQ7

   // ----------------------------------------------------------------
   // Attenuator state latch
   // ----------------------------------------------------------------
   // Serial mode ignores the parallel pins and parallel mode the shift
   // register, so a mode switch with the strobe high loads at once, into serial mode only on an address match
   logic [4:0] atten_q;
   logic [4:0] atten_d;
   logic load_en;

   always_comb begin
      atten_d = atten_q;
      load_en = 1'b0;
      if (sel_s) begin // RQ1
         // Serial: transparent while strobe high, and only on a match
         if (strobe_s && match) begin // RQ11 RQ6
            load_en = 1'b1;
            // Word is quarter-dB steps; bits 7..5 are low for valid settings
            atten_d = att_word[ATT_W-1:0]; // RQ9
         end
      end else begin
         // Parallel: strobe high follows pins, strobe low holds the last
         // value; the same latch serves direct and latched use
         if (strobe_s) begin // RQ4 RQ3
            load_en = 1'b1;
            atten_d = par_s; // RQ2
         end
      end
   end

   // Maximum attenuation until the first word is taken
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         atten_q <= ATT_RESET; // RQ16
      end else begin
         atten_q <= atten_d;
      end
   end

   // ----------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------
   // Each status flop follows its source one cycle late, so the status
   // outputs line up with ATTEN_STATE for whoever watches them together
   logic serial_q;
   logic match_q;
   logic open_q;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         serial_q <= 1'b0;
      end else begin
         serial_q <= sel_s;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         match_q <= 1'b0;
      end else begin
         match_q <= match;
      end
   end

   // Marks the cycles in which the latch took a value
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         open_q <= 1'b0;
      end else begin
         open_q <= load_en;
      end
   end

   assign ATTEN_STATE = atten_q;
   assign SERIAL_MODE = serial_q;
   assign SHIFT_WORD = shift_q;
   assign ADDR_MATCH = match_q;
   assign LATCH_OPEN = open_q;

endmodule : sat_device

`default_nettype wire

// ===== shared/sat_if.sv
// Pins between the external controller and the step attenuator.
// Assumes the controller drives every pin; parallel pins it releases read low.
`default_nettype none

interface sat_if;
   logic ser_sel;
   logic [4:0] par_bits;
   logic par_oe;
   logic [4:0] par_level;
   logic ser_clk;
   logic ser_data;
   logic load_strobe;
   logic [2:0] addr_pins;

   // Open parallel inputs are pulled low on chip
   assign par_level = par_oe ? par_bits : 5'h00; // RQ17

   modport ctrl (
      output ser_sel, par_bits, par_oe, ser_clk, ser_data, load_strobe, addr_pins
   );
   modport dev (
      input ser_sel, par_level, ser_clk, ser_data, load_strobe, addr_pins
   );
endinterface : sat_if

`default_nettype wire

// ===== shared/sat_pkg.sv
// Constants shared by both ends of the step attenuator control port.
// Assumes a single 100 MHz system clock on each end.
`default_nettype none

package sat_pkg;

   // ----------------------------------------------------------------
   // Word layout
   // ----------------------------------------------------------------
   localparam int SHIFT_LEN = 16;
   localparam int WORD_LEN = 8;
   localparam int ATT_W = 5;
   localparam int ADDR_W = 3;
   localparam logic [4:0] ATT_MAX = 5'h1f;
   localparam logic [4:0] ATT_RESET = ATT_MAX;
   localparam int ATT_LSB = 0;
   localparam int ADDR_LSB = 8;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int LINK_HALF_NS = 40;
   localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int PAR_SETUP_NS = 100;
   localparam int PAR_SETUP_CYC = (PAR_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int MAX_RATE_HZ = 25000;
   localparam int GAP_NS = 1000000000 / MAX_RATE_HZ;
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;

   // ----------------------------------------------------------------
   // Controller register map (APB byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_WORD = 8'h04;
   localparam logic [7:0] REG_PINS = 8'h08;
   localparam logic [7:0] REG_GO = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int CTRL_SERIAL_BIT = 0;
   localparam int CTRL_DIRECT_BIT = 1;
   localparam int WORD_TARGET_LSB = 8;
   localparam int STATUS_BUSY_BIT = 0;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [4:0] WORD_ATT_RESET = 5'h00;
   localparam logic [2:0] WORD_TGT_RESET = 3'h0;
   localparam logic [2:0] PINS_RESET = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_HIGH = 3'b010,
      ST_PSETUP = 3'b011,
      ST_LE_HI = 3'b100,
      ST_LE_LO = 3'b101,
      ST_GAP = 3'b110
   } sat_state_type;

endpackage : sat_pkg

`default_nettype wire

// ===== test/sat_props.sv
// Assertions on the attenuator link pins and the device state outputs.
// Assumes one MCLK domain; placed beside the link interface in the bench.
`default_nettype none

module sat_props
   import sat_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic ser_sel,
   input wire logic [4:0] par_level,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic load_strobe,
   input wire logic [2:0] addr_pins,
   input wire logic [4:0] ATTEN_STATE,
   input wire logic SERIAL_MODE,
   input wire logic [15:0] SHIFT_WORD
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   // ------------------------------
   // Strobe spacing counter
   // ------------------------------
   logic le_q;
   logic [12:0] since_q;
   // Saturates so a strobe long after reset never trips the spacing check
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         le_q <= 1'b0;
         since_q <= 13'h1fff;
      end else begin
         le_q <= load_strobe;
         if (load_strobe && !le_q) begin
            since_q <= 13'h0000;
         end else if (since_q != 13'h1fff) begin
            since_q <= since_q + 13'h0001;
         end
      end
   end

   // ------------------------------
   // Properties
   // ------------------------------
   property p_pup_max;
      $past(RST) |-> ATTEN_STATE == ATT_RESET;
   endproperty
   a_pup_max: assert property (p_pup_max) else $error("state not maximum after reset");
   property p_mode;
      $changed(ser_sel) |-> ##[1:5] SERIAL_MODE == ser_sel;
   endproperty
   a_mode: assert property (p_mode) else $error("mode select not followed");
   property p_ser_ground;
      ser_sel [*3] |-> par_level == 5'h00;
   endproperty
   a_ser_ground: assert property (p_ser_ground) else $error("parallel pins high in serial");
   property p_le_low_shift;
      ser_sel && $rose(ser_clk) |-> !load_strobe;
   endproperty
   a_le_low_shift: assert property (p_le_low_shift) else $error("strobe high while shifting");
   property p_shift_in;
      $rose(ser_clk) |-> ##4 SHIFT_WORD[15] == $past(ser_data, 4);
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");
   property p_addr_match;
      $changed(ATTEN_STATE) && SERIAL_MODE |-> SHIFT_WORD[10:8] == addr_pins;
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("load without address match");
   property p_word_load;
      $changed(ATTEN_STATE) && SERIAL_MODE |-> ATTEN_STATE == SHIFT_WORD[4:0];
   endproperty
   a_word_load: assert property (p_word_load) else $error("wrong serial word loaded");
   property p_latched;
      $fell(load_strobe) && !SERIAL_MODE |-> ##4 ATTEN_STATE == par_level;
   endproperty
   a_latched: assert property (p_latched) else $error("parallel value not latched");
   property p_direct;
      (!SERIAL_MODE && load_strobe && $stable(par_level)) [*8] |-> ATTEN_STATE == par_level;
   endproperty
   a_direct: assert property (p_direct) else $error("direct value not followed");
   property p_rate;
      load_strobe && !le_q |-> since_q >= GAP_CYC;
   endproperty
   a_rate: assert property (p_rate) else $error("state changes too fast");
endmodule : sat_props

`default_nettype wire

// ===== test/step_attenuator_control_port_bench.sv
// Bench: APB-driven controller facing the attenuator device over the link.
// Assumes the package, interface, both design ends and the checker are compiled.
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module step_attenuator_control_port_bench
   import sat_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, ser_mode, match, lopen;
   logic [4:0] atten, prev, cur;
   logic [15:0] shw;
   logic [31:0] lf = 32'hda89;
   logic [33:0] ent;
   logic [33:0] exp_q[$];
   logic [4:0] att_q[$];
   logic [7:0] regs[4] = '{REG_CTRL, REG_WORD, REG_PINS, REG_STATUS};
   logic watch = 1'b0;
   int n_errors = 0, n_checks = 0, cyc = 0;

   sat_if link ();
   sat_ctrl sat_ctrl_i (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .LINK(link));
   sat_device sat_device_i (.MCLK(mclk), .RST(rst), .LINK(link), .ATTEN_STATE(atten),
      .SERIAL_MODE(ser_mode), .SHIFT_WORD(shw), .ADDR_MATCH(match), .LATCH_OPEN(lopen));
   sat_props sat_props_i (.MCLK(mclk), .RST(rst), .ser_sel(link.ser_sel),
      .par_level(link.par_level), .ser_clk(link.ser_clk), .ser_data(link.ser_data),
      .load_strobe(link.load_strobe), .addr_pins(link.addr_pins), .ATTEN_STATE(atten),
      .SERIAL_MODE(ser_mode), .SHIFT_WORD(shw));

   initial begin
      forever #5 mclk = ~mclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   // One APB transfer; the note {check data, slverr, data} goes to the watcher
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic k, input logic [32:0] e);
      exp_q.push_back({k, e});
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   // Program a random setting for target address tgt, start it, wait out the gap
   task automatic go(input logic [2:0] tgt, input logic chg);
      logic [4:0] v;
      lf = lfsr(lf);
      v = lf[4:0];
      if (v == cur) begin
         v = ~v;
      end
      apb(1'b1, REG_WORD, {21'h0, tgt, 3'h0, v}, 1'b0, 33'h0);
      if (chg) begin
         att_q.push_back(v);
         cur = v;
      end
      apb(1'b1, REG_GO, lf, 1'b0, 33'h0);
      // Busy: this write must be dropped
      apb(1'b1, REG_WORD, 32'h0, 1'b0, 33'h0);
      apb(1'b0, REG_WORD, 32'h0, 1'b1, {1'b0, 21'h0, tgt, 3'h0, v});
      do begin
         apb(1'b0, REG_STATUS, 32'h0, 1'b0, 33'h0);
      end while (rd[0] !== 1'b0);
      if (!chg) `CHK(match, 1'b0)
      if (!chg) `CHK(atten, cur)
   endtask : go

   // ------------------------------
   // Result watcher
   // ------------------------------
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 80000) begin
         n_errors++;
         finish_test();
      end
      if (pready === 1'b1) begin
         ent = exp_q.pop_front();
         `CHK(pslverr, ent[32])
         if (ent[33]) `CHK(prdata, ent[31:0])
      end
      if (watch && atten !== prev) begin
         `CHK(atten, att_q.pop_front())
         `CHK(lopen, 1'b1)
         if (ser_mode) `CHK(match, 1'b1)
      end
      prev = atten;
   end

   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      `CHK(atten, ATT_RESET)
      cur = ATT_RESET;
      foreach (regs[i]) apb(1'b0, regs[i], 32'h0, 1'b1, 33'h0);
      apb(1'b0, 8'h14, 32'h0, 1'b1, {1'b1, 32'h0});
      apb(1'b1, 8'h14, lf, 1'b0, {1'b1, 32'h0});
      $display("done: reset and registers");
      watch = 1'b1;
      go(3'h0, 1'b1);
      go(3'h0, 1'b1);
      $display("done: latched parallel");
      apb(1'b1, REG_CTRL, 32'h1, 1'b0, 33'h0);
      for (int a = 0; a < 8; a++) begin
         apb(1'b1, REG_PINS, 32'(a), 1'b0, 33'h0);
         go(a[2:0], 1'b1);
      end
      apb(1'b1, REG_PINS, 32'h5, 1'b0, 33'h0);
      go(3'h4, 1'b0);
      go(3'h7, 1'b0);
      $display("done: serial addressable");
      // Mode switch may move the state to stale pins, so it goes unwatched
      watch = 1'b0;
      apb(1'b1, REG_CTRL, 32'h2, 1'b0, 33'h0);
      go(3'h0, 1'b1);
      att_q.delete();
      watch = 1'b1;
      go(3'h0, 1'b1);
      go(3'h0, 1'b1);
      $display("done: direct parallel");
      repeat (10) @(posedge mclk);
      `CHK(att_q.size(), 0)
      `CHK(exp_q.size(), 0)
      finish_test();
   end
endmodule : step_attenuator_control_port_bench

`default_nettype wire
